// File: rtl/ppc_regs.svh
// Register indices, field positions and reset values of the port pad control block.
// Byte address of a register is four times its index; included by the pad control modules.
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define PPC_IDX_PA_DIR     9'h002
`define PPC_IDX_PB_DIR     9'h003
`define PPC_IDX_PE_DIR     9'h009
`define PPC_IDX_PULLUP     9'h00C
`define PPC_IDX_DRV_RED    9'h00D
`define PPC_IDX_PWM_CTL    9'h054
`define PPC_IDX_PP_DIR     9'h057
`define PPC_IDX_TIM_MASK2  9'h08D
`define PPC_IDX_PT_DIR     9'h0AF
`define PPC_IDX_PS_DIR     9'h0D7
`define PPC_IDX_PS_PULLDRV 9'h0D9
`define PPC_IDX_CAN_CTL    9'h13D
`define PPC_IDX_PS_DATA    9'h1F0
`define PPC_IDX_PT_DATA    9'h1F1
`define PPC_IDX_PERIPH_EN  9'h1F2
`define PPC_IDX_PWM_EN     9'h1F3

// ----------------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------------
`define PPC_RST_ZERO       8'h00
`define PPC_RST_PULLUP     8'hD0
`define PPC_MASK_PE_DIR    8'hFC
`define PPC_MASK_PULLUP    8'hD3
`define PPC_MASK_DRV_RED   8'h6B
`define PPC_MASK_PWM_CTL   8'h30
`define PPC_MASK_PS_PD     8'h77
`define PPC_MASK_CAN_CTL   8'h03
`define PPC_MASK_PWM_EN    8'h0F

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PPC_PU_A           0
`define PPC_PU_B           1
`define PPC_PU_E           4
`define PPC_PU_G           6
`define PPC_PU_H           7
`define PPC_RD_A           0
`define PPC_RD_B           1
`define PPC_RD_E           3
`define PPC_RD_G           5
`define PPC_RD_H           6
`define PPC_PWM_PU         5
`define PPC_PWM_RD         4
`define PPC_TIM_PU         5
`define PPC_TIM_RD         4
`define PPC_CAN_PU         0
`define PPC_CAN_RD         1
`define PPC_EN_SCI1        0
`define PPC_EN_SCI0        1
`define PPC_EN_SPI         2
`define PPC_EN_TIMER       3
`define PPC_EN_PACC        4
`define PPC_WOM_SCI1       5
`define PPC_WOM_SCI0       6
`define PPC_WOM_SPI        7
`define PPC_PACC_PIN       7

`endif

// File: rtl/ppc_pkg.sv
// Types shared by the port pad control modules.
// Assumes nothing of its surroundings.
package ppc_pkg;
    typedef logic [7:0] ppc_byte_t;
    typedef enum logic [1:0] {ppc_mode_single, ppc_mode_expanded, ppc_mode_periph} ppc_mode_t;
endpackage

// File: rtl/ppc_sync.sv
// Two-stage synchroniser for a bundle of independent levels.
// Assumes each bit is a level that holds for several clock cycles.
`timescale 1ns/1ps
module ppc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // ppc_sync

// File: rtl/ppc_port_pad.sv
// Pad control for the serial and timer ports plus the pull and drive map of every port.
// Assumes an APB master on core_clk and peripherals on the same clock.
//
// Summary of operation
// R1: Serial pins are GPIO unless their function enabled.
// R2: Channel wired-OR drops high-side drive on pins 1:0/3:2.
// R3: SPI wired-OR drops high-side drive on pins 7:4.
// R4: Open drain applies to function and GPIO outputs.
// R5: Serial groups reduce drive when bit set.
// R6: Serial pull-up only on GPIO inputs, resets off.
// R7: Serial GPIO outputs never get the pull-up.
// R8: Timer and accumulator enables take over timer pins.
// R9: Timer direction bit one is output, resets input.
// R10: Timer pull-up bit pulls all timer inputs.
// R11: Timer reduced-drive bit, always readable and writable.
// R12: Reset pull-ups off except E, G, H; full drive.
// R13: Load-select pin high pulls up, low pulls down.
// R14: CAN bits 1:0 belong to the CAN controller.
// R15: PWM enable routes modulator to pins 3:0.
// R16: A/B direction registers hidden outside single-chip.
// R17: Drive-reduce register written once, hidden in peripheral.
// R18: Owning peripheral overrides data and direction.
`timescale 1ns/1ps
`include "ppc_regs.svh"
module ppc_port_pad #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              nrst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Mode straps
    input  wire logic              mode_expanded_pin,
    input  wire logic              mode_periph_pin,
    // Serial port pads and functions
    input  wire logic [7:0]        ps_in,
    output logic      [7:0]        ps_out,
    output logic      [7:0]        ps_oe,
    output logic      [7:0]        ps_pullup,
    output logic      [7:0]        ps_reduce,
    output logic      [7:0]        ps_level,
    input  wire logic [7:0]        ser_fn_out,
    input  wire logic [7:0]        ser_fn_oe,
    // Timer port pads and functions
    input  wire logic [7:0]        pt_in,
    output logic      [7:0]        pt_out,
    output logic      [7:0]        pt_oe,
    output logic      [7:0]        pt_pullup,
    output logic                   pt_reduce,
    output logic      [7:0]        pt_level,
    input  wire logic [7:0]        tim_fn_out,
    input  wire logic [7:0]        tim_fn_oe,
    // PWM port
    output logic      [7:0]        pp_dir,
    output logic      [3:0]        pp_pwm_sel,
    output logic                   pp_pullup,
    output logic                   pp_reduce,
    // Ports A, B, E, G, H pull and drive
    output logic      [7:0]        pa_dir,
    output logic      [7:0]        pb_dir,
    output logic      [7:0]        pe_dir,
    output logic      [2:0]        pabe_pullup,
    output logic      [4:0]        pabegh_reduce,
    input  wire logic              g_load_select_pin,
    input  wire logic              h_load_select_pin,
    output logic      [1:0]        gh_load_en,
    output logic      [1:0]        gh_load_up,
    // CAN port
    input  wire logic              can_tx_ctrl,
    input  wire logic              can_receive_pin,
    output logic                   can_transmit_pin,
    output logic                   can_rx_ctrl,
    output logic                   can_rx_pullup,
    output logic                   pcan_hi_pullup,
    output logic                   pcan_hi_reduce
);
    // ------------------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------------------
    logic        rst_n;
    logic [20:0] pins_q;

    ppc_sync #(.W(1)) u_rst_sync (
        .clk   (core_clk),
        .rst_n (nrst),
        .d     (1'b1),
        .q     (rst_n)
    );

    ppc_sync #(.W(21)) u_pin_sync (
        .clk   (core_clk),
        .rst_n (rst_n),
        .d     ({mode_periph_pin, mode_expanded_pin, h_load_select_pin, g_load_select_pin,
                 can_receive_pin, pt_in, ps_in}),
        .q     (pins_q)
    );

    // Straps are watched continuously; a change of mode takes effect two cycles later.
    function automatic ppc_pkg::ppc_mode_t mode_of(input logic [1:0] s);
        if (s[1])
            return ppc_pkg::ppc_mode_periph;
        else if (s[0])
            return ppc_pkg::ppc_mode_expanded;
        return ppc_pkg::ppc_mode_single;
    endfunction

    // Spreads three group bits over pins 1:0, 3:2 and 7:4.
    function automatic ppc_pkg::ppc_byte_t grp8(input logic [2:0] g);
        return {{4{g[2]}}, {2{g[1]}}, {2{g[0]}}};
    endfunction

    ppc_pkg::ppc_mode_t mode;
    logic               ab_vis;
    logic               drv_vis;

    assign mode    = mode_of(pins_q[20:19]);
    assign ab_vis  = (mode == ppc_pkg::ppc_mode_single); // R16
    assign drv_vis = (mode != ppc_pkg::ppc_mode_periph); // R17

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    ppc_pkg::ppc_byte_t pa_dir_r, pb_dir_r, pe_dir_r, pullup_r, drv_red_r, pwm_ctl_r, pp_dir_r;
    ppc_pkg::ppc_byte_t tim_mask2_r, pt_dir_r, ps_dir_r, ps_pd_r, can_ctl_r;
    ppc_pkg::ppc_byte_t ps_data_r, pt_data_r, periph_en_r, pwm_en_r;
    logic               drv_written_r;
    logic [8:0]         idx;
    logic               hit;
    logic               wr;
    ppc_pkg::ppc_byte_t rd_val;
    ppc_pkg::ppc_byte_t wd;

    assign idx = paddr[10:2];
    assign wd  = pwdata[7:0];
    assign wr  = psel && penable && pwrite && pready && hit;

    always_comb begin
        hit    = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:11] == '0);
        rd_val = `PPC_RST_ZERO;
        case (idx)
            `PPC_IDX_PA_DIR:     begin rd_val = pa_dir_r;    hit = hit && ab_vis; end
            `PPC_IDX_PB_DIR:     begin rd_val = pb_dir_r;    hit = hit && ab_vis; end
            `PPC_IDX_PE_DIR:     rd_val = pe_dir_r;
            `PPC_IDX_PULLUP:     rd_val = pullup_r;
            `PPC_IDX_DRV_RED:    begin rd_val = drv_red_r;   hit = hit && drv_vis; end
            `PPC_IDX_PWM_CTL:    rd_val = pwm_ctl_r;
            `PPC_IDX_PP_DIR:     rd_val = pp_dir_r;
            `PPC_IDX_TIM_MASK2:  rd_val = tim_mask2_r;
            `PPC_IDX_PT_DIR:     rd_val = pt_dir_r;
            `PPC_IDX_PS_DIR:     rd_val = ps_dir_r;
            `PPC_IDX_PS_PULLDRV: rd_val = ps_pd_r;
            `PPC_IDX_CAN_CTL:    rd_val = can_ctl_r;
            `PPC_IDX_PS_DATA:    rd_val = (ps_data_r & ps_dir_r) | (pins_q[7:0] & ~ps_dir_r);
            `PPC_IDX_PT_DATA:    rd_val = (pt_data_r & pt_dir_r) | (pins_q[15:8] & ~pt_dir_r);
            `PPC_IDX_PERIPH_EN:  rd_val = periph_en_r;
            `PPC_IDX_PWM_EN:     rd_val = pwm_en_r;
            default:             hit = 1'b0;
        endcase
    end

    // Zero-wait slave: the answer is prepared in the setup cycle.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata  <= (psel && !penable && !pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pa_dir_r    <= `PPC_RST_ZERO;
            pb_dir_r    <= `PPC_RST_ZERO;
            pe_dir_r    <= `PPC_RST_ZERO;
            pullup_r    <= `PPC_RST_PULLUP; // R12
            pwm_ctl_r   <= `PPC_RST_ZERO;
            pp_dir_r    <= `PPC_RST_ZERO;
            tim_mask2_r <= `PPC_RST_ZERO;   // R10 R11
            pt_dir_r    <= `PPC_RST_ZERO;   // R9
            ps_dir_r    <= `PPC_RST_ZERO;
            ps_pd_r     <= `PPC_RST_ZERO;   // R5 R6
            can_ctl_r   <= `PPC_RST_ZERO;
            ps_data_r   <= `PPC_RST_ZERO;
            pt_data_r   <= `PPC_RST_ZERO;
            periph_en_r <= `PPC_RST_ZERO;
            pwm_en_r    <= `PPC_RST_ZERO;
        end else if (wr) begin
            case (idx)
                `PPC_IDX_PA_DIR:     pa_dir_r    <= wd;
                `PPC_IDX_PB_DIR:     pb_dir_r    <= wd;
                `PPC_IDX_PE_DIR:     pe_dir_r    <= wd & `PPC_MASK_PE_DIR;
                `PPC_IDX_PULLUP:     pullup_r    <= wd & `PPC_MASK_PULLUP;
                `PPC_IDX_PWM_CTL:    pwm_ctl_r   <= wd & `PPC_MASK_PWM_CTL;
                `PPC_IDX_PP_DIR:     pp_dir_r    <= wd;
                `PPC_IDX_TIM_MASK2:  tim_mask2_r <= wd; // R11
                `PPC_IDX_PT_DIR:     pt_dir_r    <= wd;
                `PPC_IDX_PS_DIR:     ps_dir_r    <= wd;
                `PPC_IDX_PS_PULLDRV: ps_pd_r     <= wd & `PPC_MASK_PS_PD;
                `PPC_IDX_CAN_CTL:    can_ctl_r   <= wd & `PPC_MASK_CAN_CTL;
                `PPC_IDX_PS_DATA:    ps_data_r   <= wd;
                `PPC_IDX_PT_DATA:    pt_data_r   <= wd;
                `PPC_IDX_PERIPH_EN:  periph_en_r <= wd;
                `PPC_IDX_PWM_EN:     pwm_en_r    <= wd & `PPC_MASK_PWM_EN;
                default:             ;
            endcase
        end
    end

    // A second write is dropped silently; it still completes without error.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            drv_red_r     <= `PPC_RST_ZERO; // R12
            drv_written_r <= 1'b0;
        end else if (wr && idx == `PPC_IDX_DRV_RED && !drv_written_r) begin
            drv_red_r     <= wd & `PPC_MASK_DRV_RED; // R17
            drv_written_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Serial port pads
    // ------------------------------------------------------------------------
    ppc_pkg::ppc_byte_t s_own, s_wom, s_drv, s_en;

    assign s_own = grp8({periph_en_r[`PPC_EN_SPI], periph_en_r[`PPC_EN_SCI0],
                         periph_en_r[`PPC_EN_SCI1]});                               // R1
    assign s_wom = grp8({periph_en_r[`PPC_WOM_SPI], periph_en_r[`PPC_WOM_SCI0],
                         periph_en_r[`PPC_WOM_SCI1]});                              // R2 R3
    assign s_drv = (s_own & ser_fn_out) | (~s_own & ps_data_r);                     // R18
    assign s_en  = (s_own & ser_fn_oe) | (~s_own & ps_dir_r);                       // R18

    // Only the low side drives in wired-OR mode, so a one releases the pad.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ps_out    <= 8'h00;
            ps_oe     <= 8'h00;
            ps_pullup <= 8'h00;
            ps_reduce <= 8'h00;
            ps_level  <= 8'h00;
        end else begin
            ps_out    <= s_drv;
            ps_oe     <= s_en & ~(s_wom & s_drv);                  // R2 R3 R4
            ps_pullup <= grp8(ps_pd_r[2:0]) & ~ps_dir_r & ~s_own;  // R6 R7
            ps_reduce <= grp8(ps_pd_r[6:4]);                       // R5
            ps_level  <= pins_q[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // Timer port pads
    // ------------------------------------------------------------------------
    ppc_pkg::ppc_byte_t t_own, t_en;

    assign t_own = periph_en_r[`PPC_EN_TIMER] ? 8'hFF
                 : (8'(periph_en_r[`PPC_EN_PACC]) << `PPC_PACC_PIN);                 // R8
    assign t_en  = (t_own & tim_fn_oe) | (~t_own & pt_dir_r);                        // R9 R18

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pt_out    <= 8'h00;
            pt_oe     <= 8'h00;
            pt_pullup <= 8'h00;
            pt_reduce <= 1'b0;
            pt_level  <= 8'h00;
        end else begin
            pt_out    <= (t_own & tim_fn_out) | (~t_own & pt_data_r);  // R18
            pt_oe     <= t_en;                                         // R9
            pt_pullup <= {8{tim_mask2_r[`PPC_TIM_PU]}} & ~t_en;        // R10
            pt_reduce <= tim_mask2_r[`PPC_TIM_RD];                     // R11
            pt_level  <= pins_q[15:8];
        end
    end

    // ------------------------------------------------------------------------
    // Pull and drive map of the other ports
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pa_dir           <= 8'h00;
            pb_dir           <= 8'h00;
            pe_dir           <= 8'h00;
            pp_dir           <= 8'h00;
            pp_pwm_sel       <= 4'h0;
            pp_pullup        <= 1'b0;
            pp_reduce        <= 1'b0;
            pabe_pullup      <= 3'h0;
            pabegh_reduce    <= 5'h00;
            gh_load_en       <= 2'h0;
            gh_load_up       <= 2'h0;
            can_transmit_pin <= 1'b1;
            can_rx_ctrl      <= 1'b1;
            can_rx_pullup    <= 1'b0;
            pcan_hi_pullup   <= 1'b0;
            pcan_hi_reduce   <= 1'b0;
        end else begin
            pa_dir           <= pa_dir_r;
            pb_dir           <= pb_dir_r;
            pe_dir           <= pe_dir_r;
            pp_dir           <= pp_dir_r | {4'h0, pwm_en_r[3:0]};                          // R15
            pp_pwm_sel       <= pwm_en_r[3:0];                                              // R15
            pp_pullup        <= pwm_ctl_r[`PPC_PWM_PU];
            pp_reduce        <= pwm_ctl_r[`PPC_PWM_RD];
            pabe_pullup      <= {pullup_r[`PPC_PU_E], pullup_r[`PPC_PU_B], pullup_r[`PPC_PU_A]}; // R12
            pabegh_reduce    <= {drv_red_r[`PPC_RD_H], drv_red_r[`PPC_RD_G], drv_red_r[`PPC_RD_E],
                                 drv_red_r[`PPC_RD_B], drv_red_r[`PPC_RD_A]};             // R12
            gh_load_en       <= {pullup_r[`PPC_PU_H], pullup_r[`PPC_PU_G]};
            gh_load_up       <= pins_q[18:17];                                              // R13
            can_transmit_pin <= can_tx_ctrl;                                                // R14
            can_rx_ctrl      <= pins_q[16];                                                 // R14
            can_rx_pullup    <= 1'b1;
            pcan_hi_pullup   <= can_ctl_r[`PPC_CAN_PU];
            pcan_hi_reduce   <= can_ctl_r[`PPC_CAN_RD];
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_apb_answer;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("APB answer not single cycle");

    property p_sci_wom;
        periph_en_r[`PPC_WOM_SCI1] |=> (ps_oe[1:0] & ps_out[1:0]) == 2'h0;
    endproperty
    a_sci_wom: assert property (p_sci_wom) else $error("Wired-OR pin drives high"); // R2

    property p_spi_wom;
        periph_en_r[`PPC_WOM_SPI] |=> (ps_oe[7:4] & ps_out[7:4]) == 4'h0;
    endproperty
    a_spi_wom: assert property (p_spi_wom) else $error("SPI wired-OR pin drives high"); // R3

    property p_ps_pull_out;
        1'b1 |=> (ps_pullup & $past(ps_dir_r)) == 8'h00;
    endproperty
    a_ps_pull_out: assert property (p_ps_pull_out) else $error("Pull-up on serial output"); // R7

    property p_ps_gpio;
        periph_en_r[2:0] == 3'h0 |=> ps_out == $past(ps_data_r) && ps_oe == $past(ps_dir_r & ~(s_wom & ps_data_r));
    endproperty
    a_ps_gpio: assert property (p_ps_gpio) else $error("Serial GPIO path wrong"); // R1

    property p_pt_gpio;
        periph_en_r[`PPC_EN_TIMER] == 1'b0 && periph_en_r[`PPC_EN_PACC] == 1'b0 |=> pt_oe == $past(pt_dir_r);
    endproperty
    a_pt_gpio: assert property (p_pt_gpio) else $error("Timer direction not followed"); // R9

    property p_pt_pull;
        tim_mask2_r[`PPC_TIM_PU] |=> pt_pullup == ~pt_oe;
    endproperty
    a_pt_pull: assert property (p_pt_pull) else $error("Timer pull-up wrong"); // R10

    property p_drv_once;
        drv_written_r && wr && idx == `PPC_IDX_DRV_RED |=> $stable(drv_red_r) ##1 pabegh_reduce[0] == drv_red_r[0];
    endproperty
    a_drv_once: assert property (p_drv_once) else $error("Drive reduce rewritten"); // R17

    property p_ab_hidden;
        psel && !penable && !ab_vis && idx == `PPC_IDX_PA_DIR && paddr[1:0] == 2'h0 |=> pslverr ##1 $stable(pa_dir_r);
    endproperty
    a_ab_hidden: assert property (p_ab_hidden) else $error("Hidden direction register reached"); // R16

    property p_can_tx;
        1'b1 |=> can_transmit_pin == $past(can_tx_ctrl);
    endproperty
    a_can_tx: assert property (p_can_tx) else $error("CAN transmit not routed"); // R14

    c_drv_once: cover property (wr && idx == `PPC_IDX_DRV_RED ##[1:50] wr && idx == `PPC_IDX_DRV_RED);
    c_spi_wom: cover property (periph_en_r[`PPC_WOM_SPI] && periph_en_r[`PPC_EN_SPI]);
    c_timer_own: cover property (periph_en_r[`PPC_EN_TIMER] ##1 pt_oe != pt_dir_r);
endmodule // ppc_port_pad

// File: test/ppc_board.sv
// Board model at the port pins: returns the level that each pad settles to.
// Assumes registered pad controls from the pad block on core_clk.
`timescale 1ns/1ps
module ppc_board (
    // Clock
    input  wire logic       core_clk,
    // Pad controls
    input  wire logic [7:0] ps_out,
    input  wire logic [7:0] ps_oe,
    input  wire logic [7:0] ps_pullup,
    input  wire logic [7:0] pt_out,
    input  wire logic [7:0] pt_oe,
    input  wire logic [7:0] pt_pullup,
    // Pin levels
    output logic      [7:0] ps_in,
    output logic      [7:0] pt_in
);
    // A released pin without pull-up must not look stable, so it toggles every cycle.
    logic [7:0] float_r = 8'h5A;
    always @(posedge core_clk) float_r <= ~float_r;
    assign ps_in = (ps_oe & ps_out) | (~ps_oe & (ps_pullup | float_r));
    assign pt_in = (pt_oe & pt_out) | (~pt_oe & (pt_pullup | float_r));
endmodule // ppc_board

// File: test/tb.sv
// Self-checking bench for the port pad block: APB traffic, pad levels, expected values.
// Assumes the board model and the design files under rtl/.
`timescale 1ns/1ps
`include "ppc_regs.svh"
module tb;
    logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr, pt_reduce, err;
    logic        mode_expanded_pin, mode_periph_pin, g_load_select_pin, h_load_select_pin;
    logic        can_tx_ctrl, can_receive_pin, can_transmit_pin, can_rx_pullup;
    logic [7:0]  ser_fn_out, ser_fn_oe, tim_fn_out, tim_fn_oe, ps_in, ps_out, ps_oe, ps_pullup;
    logic [7:0]  ps_reduce, pt_in, pt_out, pt_oe, pt_pullup, q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pp_pwm_sel;
    logic [2:0]  pabe_pullup;
    logic [4:0]  pabegh_reduce;
    logic [1:0]  gh_load_up;
    int          failures, n_checks, d, r, m;
    int          wom_mask[4] = '{0, 8'h03, 8'h0C, 8'hF0};

    ppc_port_pad dut (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .mode_expanded_pin, .mode_periph_pin, .ps_in, .ps_out, .ps_oe, .ps_pullup, .ps_reduce, .ps_level(),
        .ser_fn_out, .ser_fn_oe, .pt_in, .pt_out, .pt_oe, .pt_pullup, .pt_reduce, .pt_level(), .tim_fn_out,
        .tim_fn_oe, .pp_dir(), .pp_pwm_sel, .pp_pullup(), .pp_reduce(), .pa_dir(), .pb_dir(), .pe_dir(),
        .pabe_pullup, .pabegh_reduce, .g_load_select_pin, .h_load_select_pin, .gh_load_en(), .gh_load_up,
        .can_tx_ctrl, .can_receive_pin, .can_transmit_pin, .can_rx_ctrl(), .can_rx_pullup,
        .pcan_hi_pullup(), .pcan_hi_reduce());
    ppc_board brd (.core_clk, .ps_out, .ps_oe, .ps_pullup, .pt_out, .pt_oe, .pt_pullup, .ps_in, .pt_in);

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Read data and response are taken at the rising edge where pready is sampled high, then the request drops.
    task automatic apb(input logic w, input logic [8:0] i, input logic [7:0] wd);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {1'b0, i, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            if (++n > 16) begin
                failures++;
                print_verdict();
            end
            @(posedge core_clk);
        end
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        chk("rdata", e, q);
    endtask
    task automatic settle();
        repeat (5) @(posedge core_clk);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    initial begin
        {nrst, psel, penable, pwrite, mode_expanded_pin, mode_periph_pin, can_receive_pin} = '0;
        {g_load_select_pin, h_load_select_pin, can_tx_ctrl, paddr, pwdata} = '0;
        {ser_fn_out, ser_fn_oe, tim_fn_out, tim_fn_oe} = '0;
        failures = 0;
        n_checks = 0;
        d = $urandom(39131);
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(`PPC_IDX_PULLUP, 8'hD0);
        rd(`PPC_IDX_PS_PULLDRV, 8'h00);
        rd(`PPC_IDX_TIM_MASK2, 8'h00);
        rd(`PPC_IDX_PT_DIR, 8'h00);
        chk("pabe_pullup", 3'b100, pabe_pullup);
        chk("pabegh_reduce", 0, pabegh_reduce);
        apb(1'b0, 9'h004, 8'h00);
        chk("pslverr", 1, err);
        r = $urandom_range(255);
        d = $urandom_range(255);
        apb(1'b1, `PPC_IDX_PS_DIR, r[7:0]);
        apb(1'b1, `PPC_IDX_PS_DATA, d[7:0]);
        apb(1'b1, `PPC_IDX_PS_PULLDRV, 8'h77);
        for (int j = 0; j < 4; j++) begin
            apb(1'b1, `PPC_IDX_PERIPH_EN, j == 0 ? 8'h00 : 8'h10 << j);
            settle();
            m = r & ~(d & wom_mask[j]);
            chk("ps_oe", m, ps_oe);
            chk("ps_out", m & d, ps_oe & ps_out);
            chk("ps_pullup", ~r & 8'hFF, ps_pullup);
            chk("ps_reduce", 8'hFF, ps_reduce);
        end
        apb(1'b1, `PPC_IDX_PT_DIR, r[7:0]);
        apb(1'b1, `PPC_IDX_TIM_MASK2, 8'h30);
        tim_fn_oe <= d[7:0];
        settle();
        chk("pt_oe", r, pt_oe);
        chk("pt_pullup", ~r & 8'hFF, pt_pullup);
        chk("pt_reduce", 1, pt_reduce);
        rd(`PPC_IDX_TIM_MASK2, 8'h30);
        apb(1'b1, `PPC_IDX_PERIPH_EN, 8'h08);
        settle();
        chk("pt_oe", d, pt_oe);
        apb(1'b1, `PPC_IDX_DRV_RED, 8'hFF);
        apb(1'b1, `PPC_IDX_DRV_RED, 8'h00);
        rd(`PPC_IDX_DRV_RED, 8'h6B);
        chk("pabegh_reduce", 5'h1F, pabegh_reduce);
        for (int j = 0; j < 2; j++) begin
            g_load_select_pin <= j[0];
            h_load_select_pin <= ~j[0];
            settle();
            chk("gh_load_up", {~j[0], j[0]}, gh_load_up);
        end
        can_tx_ctrl <= r[0];
        apb(1'b1, `PPC_IDX_PWM_EN, 8'h0F);
        settle();
        chk("can_transmit_pin", r[0], can_transmit_pin);
        chk("can_rx_pullup", 1, can_rx_pullup);
        chk("pp_pwm_sel", 4'hF, pp_pwm_sel);
        mode_expanded_pin <= 1'b1;
        settle();
        apb(1'b0, `PPC_IDX_PA_DIR, 8'h00);
        chk("pslverr", 1, err);
        print_verdict();
    end
endmodule // tb
